// File: verilog/sgpa_pkg.sv
// Constants for the six-bit general purpose port
package sgpa_pkg;
  localparam int unsigned NPIN = 6;
  // Register offsets
  localparam logic [7:0] OFF_PORT = 8'h05;
  localparam logic [7:0] OFF_PSET = 8'h06;
  localparam logic [7:0] OFF_PCLR = 8'h07;
  localparam logic [7:0] OFF_CMP = 8'h19;
  localparam logic [7:0] OFF_OPT = 8'h81;
  localparam logic [7:0] OFF_DIR = 8'h85;
  localparam logic [7:0] OFF_ANA = 8'h91;
  localparam logic [7:0] OFF_PUP = 8'h95;
  localparam logic [7:0] OFF_IOC = 8'h96;
  localparam logic [7:0] OFF_STS = 8'hA0;
  localparam logic [7:0] OFF_ICLR = 8'hA1;
  localparam logic [7:0] OFF_IEN = 8'hA2;
  // Field positions
  localparam int unsigned IN_ONLY_BIT = 3;
  localparam int unsigned GPU_DIS_BIT = 7;
  localparam int unsigned STS_CHG_BIT = 0;
  localparam int unsigned STS_XRST_BIT = 1;
  // Values after reset
  localparam logic [5:0] RST_DIR = 6'h3F;
  localparam logic [5:0] RST_PUP = 6'h37;
  localparam logic [5:0] RST_IOC = 6'h00;
  localparam logic [7:0] RST_OPT = 8'hFF;
  localparam logic [5:0] RST_ANA = 6'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [5:0] RST_LATCH = 6'h00;
  // Pins able to pull up or be analog
  localparam logic [5:0] PUP_MASK = 6'h37;
  localparam logic [5:0] ANA_MASK = 6'h37;
endpackage

// File: verilog/sgpa_port.sv
// Six-bit general purpose port with pull-ups and change interrupt
`timescale 1ns/100ps
module sgpa_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  output logic [5:0] pullup_on,
  input wire logic ext_reset_pin_enable,
  output logic ext_reset_req,
  input wire logic [5:0] periph_take,
  input wire logic [5:0] periph_out,
  input wire logic [5:0] periph_oe,
  output logic irq
);

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Pin synchroniser stages
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;

  // Software state
  logic [5:0] latch_ff, nxt_latch;
  logic [5:0] dir_ff, nxt_dir;
  logic [5:0] pup_ff, nxt_pup;
  logic [5:0] ioc_ff, nxt_ioc;
  logic [7:0] opt_ff, nxt_opt;
  logic [5:0] ana_ff, nxt_ana;
  logic [7:0] cmp_ff, nxt_cmp;
  logic [1:0] ien_ff, nxt_ien;

  // Hardware state
  logic [5:0] old_ff, nxt_old;
  logic [1:0] sts_ff, nxt_sts;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] pin_out_ff, nxt_pin_out;
  logic [5:0] pin_oe_n_ff, nxt_pin_oe_n;
  logic [5:0] pull_ff, nxt_pull;
  logic xrst_ff, nxt_xrst;
  logic irq_ff, nxt_irq;

  // Combinational helpers
  logic [5:0] pin_level;
  logic mismatch;
  logic port_touch;

  // Two flops on the asynchronous pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Input-only pin starts at its idle high level: no false reset edge
      sync1_ff <= 6'h08;
      sync2_ff <= 6'h08;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Pin level as seen by software
  always_comb begin
    pin_level = sync2_ff & ~(ana_ff & sgpa_pkg::ANA_MASK);
    if (ext_reset_pin_enable) begin
      pin_level[sgpa_pkg::IN_ONLY_BIT] = 1'b0;
    end
    mismatch = |((sync2_ff ^ old_ff) & ioc_ff);
    port_touch = (rd_en | wr_en) & hit(addr, sgpa_pkg::OFF_PORT);
  end

  // Next values of the software registers
  always_comb begin
    nxt_latch = latch_ff;
    nxt_dir = dir_ff;
    nxt_pup = pup_ff;
    nxt_ioc = ioc_ff;
    nxt_opt = opt_ff;
    nxt_ana = ana_ff;
    nxt_cmp = cmp_ff;
    nxt_ien = ien_ff;
    if (wr_en) begin
      // Low six bits of the byte become the latch
      if (hit(addr, sgpa_pkg::OFF_PORT)) begin
        nxt_latch = wdata[5:0];
      end
      // Bit set: sampled pins merged with mask
      if (hit(addr, sgpa_pkg::OFF_PSET)) begin
        nxt_latch = pin_level | wdata[5:0];
      end
      // Bit clear: sampled pins with mask removed
      if (hit(addr, sgpa_pkg::OFF_PCLR)) begin
        nxt_latch = pin_level & ~wdata[5:0];
      end
      // Input-only bit stays set
      if (hit(addr, sgpa_pkg::OFF_DIR)) begin
        nxt_dir = wdata[5:0];
        nxt_dir[sgpa_pkg::IN_ONLY_BIT] = 1'b1;
      end
      if (hit(addr, sgpa_pkg::OFF_PUP)) begin
        nxt_pup = wdata[5:0] & sgpa_pkg::PUP_MASK;
      end
      if (hit(addr, sgpa_pkg::OFF_IOC)) begin
        nxt_ioc = wdata[5:0];
      end
      if (hit(addr, sgpa_pkg::OFF_OPT)) begin
        nxt_opt = wdata;
      end
      if (hit(addr, sgpa_pkg::OFF_ANA)) begin
        nxt_ana = wdata[5:0] & sgpa_pkg::ANA_MASK;
      end
      if (hit(addr, sgpa_pkg::OFF_CMP)) begin
        nxt_cmp = wdata;
      end
      if (hit(addr, sgpa_pkg::OFF_IEN)) begin
        nxt_ien = wdata[1:0];
      end
    end
  end

  // Register the software state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_ff <= sgpa_pkg::RST_LATCH;
      dir_ff <= sgpa_pkg::RST_DIR;
      pup_ff <= sgpa_pkg::RST_PUP;
      ioc_ff <= sgpa_pkg::RST_IOC;
      opt_ff <= sgpa_pkg::RST_OPT;
      ana_ff <= sgpa_pkg::RST_ANA;
      cmp_ff <= sgpa_pkg::RST_CMP;
      ien_ff <= 2'h0;
    end else begin
      latch_ff <= nxt_latch;
      dir_ff <= nxt_dir;
      pup_ff <= nxt_pup;
      ioc_ff <= nxt_ioc;
      opt_ff <= nxt_opt;
      ana_ff <= nxt_ana;
      cmp_ff <= nxt_cmp;
      ien_ff <= nxt_ien;
    end
  end

  // Next values of the hardware state
  always_comb begin
    // Any read or write of the port register re-arms the change reference
    nxt_old = port_touch ? sync2_ff : old_ff;
    nxt_sts = sts_ff;
    // Clear first so that a same-cycle event wins
    if (wr_en && hit(addr, sgpa_pkg::OFF_ICLR)) begin
      nxt_sts = sts_ff & ~wdata[1:0];
    end
    if (mismatch) begin
      nxt_sts[sgpa_pkg::STS_CHG_BIT] = 1'b1;
    end
    nxt_xrst = ext_reset_pin_enable & ~sync2_ff[sgpa_pkg::IN_ONLY_BIT];
    if (nxt_xrst && !xrst_ff) begin
      nxt_sts[sgpa_pkg::STS_XRST_BIT] = 1'b1;
    end
    nxt_irq = |(nxt_sts & ien_ff);
    // Pin drivers: peripheral takes over where enabled
    nxt_pin_oe_n = dir_ff;
    nxt_pin_out = latch_ff;
    for (int i = 0; i < sgpa_pkg::NPIN; i++) begin
      if (periph_take[i]) begin
        nxt_pin_oe_n[i] = ~periph_oe[i];
        nxt_pin_out[i] = periph_out[i];
      end
    end
    nxt_pin_oe_n[sgpa_pkg::IN_ONLY_BIT] = 1'b1;
    // Pull-up needs enable, global permit and input mode
    nxt_pull = pup_ff & nxt_pin_oe_n & sgpa_pkg::PUP_MASK;
    if (opt_ff[sgpa_pkg::GPU_DIS_BIT]) begin
      nxt_pull = 6'h00;
    end
    // Read data, one cycle after the strobe
    nxt_rdata = 8'h00;
    if (rd_en) begin
      unique case (addr)
        sgpa_pkg::OFF_PORT: nxt_rdata = {2'b00, pin_level};
        sgpa_pkg::OFF_DIR: nxt_rdata = {2'b00, dir_ff};
        sgpa_pkg::OFF_PUP: nxt_rdata = {2'b00, pup_ff};
        sgpa_pkg::OFF_IOC: nxt_rdata = {2'b00, ioc_ff};
        sgpa_pkg::OFF_OPT: nxt_rdata = opt_ff;
        sgpa_pkg::OFF_ANA: nxt_rdata = {2'b00, ana_ff};
        sgpa_pkg::OFF_CMP: nxt_rdata = cmp_ff;
        sgpa_pkg::OFF_STS: nxt_rdata = {6'h00, sts_ff};
        sgpa_pkg::OFF_IEN: nxt_rdata = {6'h00, ien_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register the hardware state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      old_ff <= 6'h00;
      sts_ff <= 2'h0;
      rdata_ff <= 8'h00;
      pin_out_ff <= 6'h00;
      pin_oe_n_ff <= 6'h3F;
      pull_ff <= 6'h00;
      xrst_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      old_ff <= nxt_old;
      sts_ff <= nxt_sts;
      rdata_ff <= nxt_rdata;
      pin_out_ff <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
      pull_ff <= nxt_pull;
      xrst_ff <= nxt_xrst;
      irq_ff <= nxt_irq;
    end
  end

  // Outputs straight from flops
  assign rdata = rdata_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;
  assign pullup_on = pull_ff;
  assign ext_reset_req = xrst_ff;
  assign irq = irq_ff;

  // Input-only pin never drives
  property p_in_only_undriven;
    @(posedge clk) disable iff (!reset_n)
      pin_oe_n_ff[sgpa_pkg::IN_ONLY_BIT];
  endproperty
  a_in_only_undriven: assert property (p_in_only_undriven)
    else $error("input-only pin driven");

  // Direction readback keeps input-only bit
  property p_dir_read;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == sgpa_pkg::OFF_DIR |=> rdata_ff[3] && rdata_ff[7:6] == 2'b00;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction readback wrong");

  // Port read: levels, analog zero, reset-enabled pin zero, upper zero
  property p_port_read;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == sgpa_pkg::OFF_PORT |=>
        rdata_ff == ({2'b00, $past(sync2_ff) & ~$past(ana_ff)}
        & ~{4'h0, $past(ext_reset_pin_enable), 3'h0});
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port read value wrong");

  // Reset-enabled input-only pin reads zero
  property p_xrst_zero;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == sgpa_pkg::OFF_PORT && ext_reset_pin_enable |=> !rdata_ff[3];
  endproperty
  a_xrst_zero: assert property (p_xrst_zero)
    else $error("input-only pin not zero");

  // Pull-up only on input pins
  property p_pull_input;
    @(posedge clk) disable iff (!reset_n)
      (pull_ff & ~pin_oe_n_ff) == 6'h00;
  endproperty
  a_pull_input: assert property (p_pull_input)
    else $error("pull-up on driven pin");

  // Global disable kills every pull-up
  property p_global_pull;
    @(posedge clk) disable iff (!reset_n)
      opt_ff[7] |=> pull_ff == 6'h00;
  endproperty
  a_global_pull: assert property (p_global_pull)
    else $error("pull-up despite global disable");

  // Mismatch sets the change flag next cycle
  property p_chg_set;
    @(posedge clk) disable iff (!reset_n)
      mismatch |=> sts_ff[0];
  endproperty
  a_chg_set: assert property (p_chg_set)
    else $error("change flag not set");

  // Port access re-arms the reference
  property p_chg_end;
    @(posedge clk) disable iff (!reset_n)
      port_touch |=> old_ff == $past(sync2_ff);
  endproperty
  a_chg_end: assert property (p_chg_end)
    else $error("reference not updated");

  // Port write does not drive an input pin
  property p_write_input;
    @(posedge clk) disable iff (!reset_n)
      wr_en && addr == sgpa_pkg::OFF_PORT && dir_ff == 6'h3F
        && periph_take == 6'h00 |=> pin_oe_n_ff == 6'h3F;
  endproperty
  a_write_input: assert property (p_write_input)
    else $error("input pin driven after write");

endmodule

// File: tb/sgpa_board.sv
// Board-side model that resolves the level of each port pin
`timescale 1ns/100ps
module sgpa_board (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] pullup_on,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pin_in
);
  logic [5:0] float_ff = 6'h2A; // Changing level seen on a floating pin

  // Floating pins toggle every cycle so that a stale value is never trusted
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  // Device drive wins, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pullup_on[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_ff[i];
      end
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the six-bit port
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0; // Core clock
  logic reset_n = 1'b0; // Active-low reset
  logic [7:0] addr = 8'h00, wdata = 8'h00; // Bus address and data
  logic wr_en = 1'b0, rd_en = 1'b0; // Bus strobes
  logic [7:0] rdata; // Bus read data
  logic [5:0] pin_in, pin_out, pin_oe_n, pullup_on; // Pin side
  logic xre = 1'b0; // External reset function enable
  logic ext_reset_req, irq; // Device requests
  logic [5:0] periph_take = 6'h00, periph_out = 6'h00, periph_oe = 6'h00;
  logic [5:0] ext_en = 6'h3F, ext_val = 6'h00; // Board drive
  logic [7:0] rd_v; // Last read value
  int bad_count = 0, comparisons = 0, cycles = 0;

  sgpa_port dut (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .pin_in,
    .pin_out, .pin_oe_n, .pullup_on, .ext_reset_pin_enable(xre), .ext_reset_req,
    .periph_take, .periph_out, .periph_oe, .irq);
  sgpa_board board (.clk, .pin_out, .pin_oe_n, .pullup_on, .ext_en, .ext_val,
    .pin_in);

  // Clock generator
  initial begin
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_v = rdata;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Values after reset
  task automatic t_reset();
    chk({2'h0, pin_oe_n}, 8'h3F);
    chk({2'h0, pullup_on}, 8'h00);
    rd(sgpa_pkg::OFF_DIR);
    chk(rd_v, 8'h3F);
    rd(sgpa_pkg::OFF_PUP);
    chk(rd_v, 8'h37);
    rd(sgpa_pkg::OFF_IOC);
    chk(rd_v, 8'h00);
    rd(sgpa_pkg::OFF_OPT);
    chk(rd_v, 8'hFF);
  endtask

  // Storage registers, analog mask and write-only clear
  task automatic t_regs();
    wr(sgpa_pkg::OFF_CMP, 8'h5A);
    wr(sgpa_pkg::OFF_ANA, 8'h3F);
    rd(sgpa_pkg::OFF_CMP);
    chk(rd_v, 8'h5A);
    rd(sgpa_pkg::OFF_ANA);
    chk(rd_v, 8'h37);
    rd(sgpa_pkg::OFF_ICLR);
    chk(rd_v, 8'h00);
    wr(sgpa_pkg::OFF_ANA, 8'h00);
    wr(sgpa_pkg::OFF_CMP, 8'h00);
  endtask

  // Direction control and latch drive
  task automatic t_drive();
    ext_val <= 6'h08;
    wr(sgpa_pkg::OFF_DIR, 8'h00);
    rd(sgpa_pkg::OFF_DIR);
    chk(rd_v, 8'h08);
    wr(sgpa_pkg::OFF_PORT, 8'h15);
    settle();
    chk({2'h0, pin_oe_n}, 8'h08);
    rd(sgpa_pkg::OFF_PORT);
    chk(rd_v, 8'h1D);
    wr(sgpa_pkg::OFF_DIR, 8'h3F);
    wr(sgpa_pkg::OFF_PORT, 8'h2A);
    settle();
    chk({2'h0, pin_oe_n}, 8'h3F);
    rd(sgpa_pkg::OFF_PORT);
    chk(rd_v, 8'h08);
  endtask

  task automatic t_rmw();
    ext_val <= 6'h01;
    settle();
    wr(sgpa_pkg::OFF_PSET, 8'h02);
    settle();
    chk({2'h0, pin_out}, 8'h03);
    wr(sgpa_pkg::OFF_PCLR, 8'h01);
    settle();
    chk({2'h0, pin_out}, 8'h00);
  endtask

  task automatic t_pull();
    ext_en <= 6'h00;
    wr(sgpa_pkg::OFF_OPT, 8'h7F);
    settle();
    chk({2'h0, pullup_on}, 8'h37);
    wr(sgpa_pkg::OFF_DIR, 8'h3C);
    settle();
    chk({2'h0, pullup_on}, 8'h34);
    wr(sgpa_pkg::OFF_DIR, 8'h3F);
    wr(sgpa_pkg::OFF_OPT, 8'hFF);
    settle();
    chk({2'h0, pullup_on}, 8'h00);
    ext_en <= 6'h3F;
  endtask

  // Analog pins and the external reset function
  task automatic t_ana();
    ext_val <= 6'h3F;
    wr(sgpa_pkg::OFF_ANA, 8'h01);
    settle();
    rd(sgpa_pkg::OFF_PORT);
    chk(rd_v, 8'h3E);
    @(posedge clk);
    xre <= 1'b1;
    rd(sgpa_pkg::OFF_PORT);
    chk(rd_v, 8'h36);
    ext_val <= 6'h37;
    settle();
    chk({7'h00, ext_reset_req}, 8'h01);
    rd(sgpa_pkg::OFF_STS);
    chk(rd_v, 8'h02);
    @(posedge clk);
    xre <= 1'b0;
    wr(sgpa_pkg::OFF_ANA, 8'h00);
    settle();
    chk({7'h00, ext_reset_req}, 8'h00);
  endtask

  // Change detection: the reference is re-armed before the flag is cleared
  task automatic t_ioc();
    ext_val <= 6'h00;
    wr(sgpa_pkg::OFF_IEN, 8'h01);
    wr(sgpa_pkg::OFF_IOC, 8'h01);
    settle();
    rd(sgpa_pkg::OFF_PORT);
    wr(sgpa_pkg::OFF_ICLR, 8'h03);
    ext_val <= 6'h02;
    settle();
    chk({7'h00, irq}, 8'h00);
    ext_val <= 6'h03;
    for (int i = 0; i < 10 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    wr(sgpa_pkg::OFF_ICLR, 8'h01);
    rd(sgpa_pkg::OFF_STS);
    chk(rd_v, 8'h01);
    rd(sgpa_pkg::OFF_PORT);
    wr(sgpa_pkg::OFF_ICLR, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h00);
    rd(sgpa_pkg::OFF_STS);
    chk(rd_v, 8'h00);
  endtask

  // Peripheral takeover; the input-only pin stays undriven
  task automatic t_periph();
    @(posedge clk);
    periph_take <= 6'h09;
    periph_oe <= 6'h09;
    periph_out <= 6'h01;
    settle();
    chk({2'h0, pin_oe_n}, 8'h3E);
    chk({7'h00, pin_out[0]}, 8'h01);
    @(posedge clk);
    periph_take <= 6'h00;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    t_reset();
    t_regs();
    t_drive();
    t_rmw();
    t_pull();
    t_ana();
    t_ioc();
    t_periph();
    stop_test();
  end
endmodule
